// ### byte_alu_pkg.sv
package byte_alu_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte offsets
    localparam logic [11:0] OFF_CMD    = 12'h000;
    localparam logic [11:0] OFF_ACC    = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_PTR0   = 12'h00c;
    localparam logic [11:0] OFF_PTR1   = 12'h010;
    localparam logic [11:0] OFF_FILE   = 12'h200;  // 128 words, one per file register

    // File register space
    localparam int FILE_DEPTH = 128;
    localparam int FILE_AW    = 7;

    // Status register bit positions
    localparam int ST_C_BIT   = 0;
    localparam int ST_DC_BIT  = 1;
    localparam int ST_Z_BIT   = 2;
    localparam int ST_BAD_BIT = 3;

    // Reset values
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [15:0] PTR_RST  = 16'h0000;
    localparam logic [7:0]  FILE_RST = 8'h00;
    localparam logic        FLAG_RST = 1'b0;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operation codes carried in the command word
    typedef enum logic [3:0] {
        OP_NOP,
        OP_PTR_ADD,
        OP_AND_IMM,
        OP_ADD_IMM,
        OP_AND_FILE,
        OP_ADD_FILE,
        OP_ASR_FILE,
        OP_ADDC_FILE,
        OP_BIT_CLEAR
    } op_t;

    // Command word layout, bit 31 down to bit 0
    typedef struct packed {
        logic [6:0] spare_hi;   // 31:25
        logic       ptr_sel;    // 24
        logic [7:0] imm;        // 23:16, pointer add uses 21:16 signed
        logic       spare_lo;   // 15
        logic [6:0] faddr;      // 14:8
        logic [2:0] bsel;       // 7:5
        logic       dest;       // 4, 0 = accumulator, 1 = file register
        op_t        op;         // 3:0
    } cmd_t;

    // Result of the 8-bit adder
    typedef struct packed {
        logic       dc;
        logic       c;
        logic [7:0] sum;
    } add_res_t;

endpackage

// ### byte_alu.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

module byte_alu (
    input  wire logic        MCLK,     // Core clock, 250 MHz
    input  wire logic        RST,      // Asynchronous reset, active high
    input  wire logic [11:0] AWADDR,   // Write address
    input  wire logic        AWVALID,  // Write address valid
    output logic             AWREADY,  // Write address ready
    input  wire logic [31:0] WDATA,    // Write data
    input  wire logic [3:0]  WSTRB,    // Write byte strobes
    input  wire logic        WVALID,   // Write data valid
    output logic             WREADY,   // Write data ready
    output logic [1:0]       BRESP,    // Write response
    output logic             BVALID,   // Write response valid
    input  wire logic        BREADY,   // Write response ready
    input  wire logic [11:0] ARADDR,   // Read address
    input  wire logic        ARVALID,  // Read address valid
    output logic             ARREADY,  // Read address ready
    output logic [31:0]      RDATA,    // Read data
    output logic [1:0]       RRESP,    // Read response
    output logic             RVALID,   // Read data valid
    input  wire logic        RREADY    // Read data ready
);

    // Byte-strobe merge of new data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction
    // True when the address is a word-aligned address in the file register window
    function automatic logic is_file(input logic [11:0] a);
        return (a[11:9] == byte_alu_pkg::OFF_FILE[11:9]) && (a[1:0] == 2'h0);
    endfunction
    // Word index into the file register window
    function automatic logic [6:0] file_idx(input logic [11:0] a);
        return a[8:2];
    endfunction
    // 8-bit add with carry in, reporting carry out of bits 3 and 7
    function automatic byte_alu_pkg::add_res_t add8(input logic [7:0] a, input logic [7:0] b,
                                                    input logic cin);
        byte_alu_pkg::add_res_t r;
        logic [8:0] full;
        logic [4:0] low;
        full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.sum = full[7:0];
        r.c   = full[8];
        r.dc  = low[4];
        return r;
    endfunction
    // Bus channel state
    logic        aw_full_q;
    logic [11:0] aw_addr_q;
    logic        w_full_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    // Architectural state
    logic [7:0]  acc_q;
    logic        c_q;
    logic        dc_q;
    logic        z_q;
    logic        bad_q;
    logic [15:0] ptr_q [2];
    logic [7:0]  file_q [byte_alu_pkg::FILE_DEPTH];
    // Write decode
    logic                do_write;
    logic [31:0]         wr_word;
    logic                wr_mapped;
    byte_alu_pkg::cmd_t  cmd;
    logic                exec;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign wr_word  = merge(32'h0000_0000, w_data_q, w_strb_q);
    assign cmd      = byte_alu_pkg::cmd_t'(wr_word);
    assign exec     = do_write && (aw_addr_q == byte_alu_pkg::OFF_CMD);
    assign wr_mapped = (aw_addr_q == byte_alu_pkg::OFF_CMD) ||
                       (aw_addr_q == byte_alu_pkg::OFF_ACC) ||
                       (aw_addr_q == byte_alu_pkg::OFF_STATUS) ||
                       (aw_addr_q == byte_alu_pkg::OFF_PTR0) ||
                       (aw_addr_q == byte_alu_pkg::OFF_PTR1) ||
                       is_file(aw_addr_q);
    // Execution results
    logic [7:0]             res;
    logic                   wr_acc;
    logic                   wr_file;
    logic                   upd_c;
    logic                   upd_dc;
    logic                   upd_z;
    logic                   new_c;
    logic                   new_dc;
    logic                   wr_ptr;
    logic [15:0]            new_ptr;
    logic                   op_bad;
    logic [7:0]             fval;
    byte_alu_pkg::add_res_t sum;
    // Operation decode and datapath
    always_comb begin
        res     = 8'h00;
        wr_acc  = 1'b0;
        wr_file = 1'b0;
        upd_c   = 1'b0;
        upd_dc  = 1'b0;
        upd_z   = 1'b0;
        new_c   = 1'b0;
        new_dc  = 1'b0;
        wr_ptr  = 1'b0;
        op_bad  = 1'b0;
        fval    = file_q[cmd.faddr];
        new_ptr = ptr_q[cmd.ptr_sel] + {{10{cmd.imm[5]}}, cmd.imm[5:0]};
        sum     = add8(acc_q, fval, 1'b0);
        case (cmd.op)
            byte_alu_pkg::OP_NOP: begin
            end
            byte_alu_pkg::OP_PTR_ADD: begin
                wr_ptr = 1'b1;
            end
            byte_alu_pkg::OP_AND_IMM: begin
                res    = acc_q & cmd.imm;
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            byte_alu_pkg::OP_ADD_IMM: begin
                sum    = add8(acc_q, cmd.imm, 1'b0);
                res    = sum.sum;
                wr_acc = 1'b1;
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            byte_alu_pkg::OP_AND_FILE: begin
                res    = acc_q & fval;
                upd_z  = 1'b1;
                wr_acc = !cmd.dest;
                wr_file = cmd.dest;
            end
            byte_alu_pkg::OP_ADD_FILE: begin
                res    = sum.sum;
                {upd_c, upd_dc, upd_z} = 3'h7;
                wr_acc = !cmd.dest;
                wr_file = cmd.dest;
            end
            byte_alu_pkg::OP_ASR_FILE: begin
                res    = {fval[7], fval[7:1]};
                upd_c  = 1'b1;
                upd_z  = 1'b1;
                wr_acc = !cmd.dest;
                wr_file = cmd.dest;
            end
            byte_alu_pkg::OP_ADDC_FILE: begin
                sum    = add8(acc_q, fval, c_q);
                res    = sum.sum;
                {upd_c, upd_dc, upd_z} = 3'h7;
                wr_acc = !cmd.dest;
                wr_file = cmd.dest;
            end
            byte_alu_pkg::OP_BIT_CLEAR: begin
                res     = fval & ~(8'h01 << cmd.bsel);
                wr_file = 1'b1;
            end
            default: begin
                op_bad = 1'b1;
            end
        endcase
        new_c  = (cmd.op == byte_alu_pkg::OP_ASR_FILE) ? fval[0] : sum.c;
        new_dc = sum.dc;
    end
    // Accumulator: bus write or operation result
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_q <= byte_alu_pkg::ACC_RST;
        end else if (do_write && aw_addr_q == byte_alu_pkg::OFF_ACC) begin
            acc_q <= wr_word[7:0];
        end else if (exec && wr_acc) begin
            acc_q <= res;
        end
    end
    // Flags: bus write, or update of the flags the operation names, with BAD rewritten by every command
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            c_q   <= byte_alu_pkg::FLAG_RST;
            dc_q  <= byte_alu_pkg::FLAG_RST;
            z_q   <= byte_alu_pkg::FLAG_RST;
            bad_q <= byte_alu_pkg::FLAG_RST;
        end else if (do_write && aw_addr_q == byte_alu_pkg::OFF_STATUS) begin
            if (w_strb_q[0]) begin
                c_q  <= w_data_q[byte_alu_pkg::ST_C_BIT];
                dc_q <= w_data_q[byte_alu_pkg::ST_DC_BIT];
                z_q  <= w_data_q[byte_alu_pkg::ST_Z_BIT];
            end
        end else if (exec) begin
            bad_q <= op_bad;
            if (upd_c) begin
                c_q <= new_c;
            end
            if (upd_dc) begin
                dc_q <= new_dc;
            end
            if (upd_z) begin
                z_q <= (res == 8'h00);
            end
        end
    end
    // Indirect pointer pair
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ptr_q[0] <= byte_alu_pkg::PTR_RST;
            ptr_q[1] <= byte_alu_pkg::PTR_RST;
        end else if (do_write && aw_addr_q == byte_alu_pkg::OFF_PTR0) begin
            ptr_q[0] <= 16'(merge({16'h0000, ptr_q[0]}, w_data_q, w_strb_q));
        end else if (do_write && aw_addr_q == byte_alu_pkg::OFF_PTR1) begin
            ptr_q[1] <= 16'(merge({16'h0000, ptr_q[1]}, w_data_q, w_strb_q));
        end else if (exec && wr_ptr) begin
            ptr_q[cmd.ptr_sel] <= new_ptr;
        end
    end
    // File registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < byte_alu_pkg::FILE_DEPTH; i++) begin
                file_q[i] <= byte_alu_pkg::FILE_RST;
            end
        end else if (do_write && is_file(aw_addr_q)) begin
            if (w_strb_q[0]) begin
                file_q[file_idx(aw_addr_q)] <= w_data_q[7:0];
            end
        end else if (exec && wr_file) begin
            file_q[cmd.faddr] <= res;
        end
    end
    // Write address and data channels, taken in either order
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            awready_q <= 1'b1;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            wready_q  <= 1'b1;
        end else begin
            if (AWVALID && awready_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= AWADDR;
                awready_q <= 1'b0;
            end else if (do_write) begin
                aw_full_q <= 1'b0;
                awready_q <= 1'b1;
            end
            if (WVALID && wready_q) begin
                w_full_q <= 1'b1;
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
                wready_q <= 1'b0;
            end else if (do_write) begin
                w_full_q <= 1'b0;
                wready_q <= 1'b1;
            end
        end
    end
    // Write response
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= byte_alu_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? byte_alu_pkg::RESP_OKAY : byte_alu_pkg::RESP_SLVERR;
        end else if (BREADY && bvalid_q) begin
            bvalid_q <= 1'b0;
        end
    end
    // Read data mux
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (is_file(ARADDR)) begin
            rd_word[7:0] = file_q[file_idx(ARADDR)];
        end else begin
            unique case (ARADDR)
                byte_alu_pkg::OFF_CMD:    rd_word = 32'h0000_0000;
                byte_alu_pkg::OFF_ACC:    rd_word[7:0] = acc_q;
                byte_alu_pkg::OFF_STATUS: rd_word[3:0] = {bad_q, z_q, dc_q, c_q};
                byte_alu_pkg::OFF_PTR0:   rd_word[15:0] = ptr_q[0];
                byte_alu_pkg::OFF_PTR1:   rd_word[15:0] = ptr_q[1];
                default:                  rd_ok = 1'b0;
            endcase
        end
    end
    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= byte_alu_pkg::RESP_OKAY;
        end else if (ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_ok ? byte_alu_pkg::RESP_OKAY : byte_alu_pkg::RESP_SLVERR;
        end else if (RREADY && rvalid_q) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end
    // Port drivers, all from flip-flops
    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;

endmodule

// ### byte_alu_props.sv
`timescale 1ns/10ps

// Handshake and answer checks on the register port
module byte_alu_chk (
    input logic        MCLK,     // Core clock
    input logic        RST,      // Reset, active high
    input logic        AWVALID,  // Write address valid
    input logic        AWREADY,  // Write address ready
    input logic        WVALID,   // Write data valid
    input logic        WREADY,   // Write data ready
    input logic [1:0]  BRESP,    // Write response
    input logic        BVALID,   // Write response valid
    input logic        BREADY,   // Write response ready
    input logic        ARVALID,  // Read address valid
    input logic        ARREADY,  // Read address ready
    input logic [31:0] RDATA,    // Read data
    input logic [1:0]  RRESP,    // Read response
    input logic        RVALID,   // Read data valid
    input logic        RREADY    // Read data ready
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // Answers arrive within a bounded time
    wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
        else $error("write response late");
    rd_answer_a: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
        else $error("read data late");
    // Answers stand until taken
    b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read data dropped");
    // Answers end after their handshake
    b_release_a: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response repeated");
    r_release_a: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data repeated");
    // No second read taken while one is answered
    ar_busy_a: assert property (RVALID |-> !ARREADY)
        else $error("read address accepted while busy");
    // Only the two documented response codes on the write response
    resp_code_a: assert property (BVALID |-> BRESP == 2'h0 || BRESP == 2'h2)
        else $error("bad write response code");
endmodule

bind byte_alu byte_alu_chk i_chk (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY));

// ### tb_byte_alu.sv
`timescale 1ns/10ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_byte_alu;
    logic        MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rdat;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, resp;
    int          failures = 0;
    int          compares = 0;
    localparam logic [11:0] a_acc = byte_alu_pkg::OFF_ACC;
    localparam logic [11:0] a_st  = byte_alu_pkg::OFF_STATUS;
    localparam logic [11:0] a_p0  = byte_alu_pkg::OFF_PTR0;
    localparam logic [11:0] a_p1  = byte_alu_pkg::OFF_PTR1;

    // Device under test
    byte_alu i_dut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // Clock
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    function automatic logic [11:0] fa(input int i);
        return byte_alu_pkg::OFF_FILE + 12'(4 * i);
    endfunction

    // Bus write, held until each channel is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        AWADDR  <= a;
        AWVALID <= 1'b1;
        WDATA   <= d;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        forever begin
            @(posedge MCLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID && BREADY) begin
                resp = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
    endtask

    // Bus read
    task automatic rd(input logic [11:0] a);
        @(posedge MCLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        forever begin
            @(posedge MCLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID && RREADY) begin
                rdat = RDATA;
                resp = RRESP;
                RREADY <= 1'b0;
                break;
            end
        end
    endtask

    task automatic c(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK(rdat, e)
        `CHK(resp, byte_alu_pkg::RESP_OKAY)
    endtask

    // Issue one command word
    task automatic ex(input byte_alu_pkg::op_t op, input logic d, input logic [2:0] b,
                      input logic [6:0] f, input logic [7:0] k, input logic p);
        byte_alu_pkg::cmd_t cw;
        cw = '0;
        cw.op = op;
        cw.dest = d;
        cw.bsel = b;
        cw.faddr = f;
        cw.imm = k;
        cw.ptr_sel = p;
        wr(byte_alu_pkg::OFF_CMD, cw);
        `CHK(resp, byte_alu_pkg::RESP_OKAY)
    endtask

    task automatic t_reset;
        c(a_acc, 32'h0);
        c(a_st, 32'h0);
        c(a_p1, 32'h0);
        c(fa(127), 32'h0);
        wr(12'h014, 32'h5);
        `CHK(resp, byte_alu_pkg::RESP_SLVERR)
        rd(12'h014);
        `CHK(rdat, 32'h0)
        `CHK(resp, byte_alu_pkg::RESP_SLVERR)
    endtask

    task automatic t_ptr;
        wr(a_st, 32'h7);
        wr(a_p0, 32'hfffe);
        ex(byte_alu_pkg::OP_PTR_ADD, 1'b0, 3'h0, 7'h0, 8'h1f, 1'b0);
        c(a_p0, 32'h001d);
        wr(a_p1, 32'h5);
        ex(byte_alu_pkg::OP_PTR_ADD, 1'b0, 3'h0, 7'h0, 8'h20, 1'b1);
        c(a_p1, 32'hffe5);
        c(a_p0, 32'h001d);
        c(a_st, 32'h7);
    endtask

    task automatic t_imm;
        wr(a_acc, 32'hf0);
        wr(a_st, 32'h3);
        ex(byte_alu_pkg::OP_AND_IMM, 1'b0, 3'h0, 7'h0, 8'h0f, 1'b0);
        c(a_acc, 32'h0);
        c(a_st, 32'h7);
        wr(a_st, 32'h0);
        wr(a_acc, 32'h8f);
        ex(byte_alu_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h0, 8'h71, 1'b0);
        c(a_acc, 32'h0);
        c(a_st, 32'h7);
        wr(a_acc, 32'hf0);
        ex(byte_alu_pkg::OP_ADD_IMM, 1'b0, 3'h0, 7'h0, 8'h20, 1'b0);
        c(a_acc, 32'h10);
        c(a_st, 32'h1);
    endtask

    task automatic t_file;
        wr(fa(127), 32'h3c);
        wr(a_acc, 32'hf5);
        wr(a_st, 32'h3);
        ex(byte_alu_pkg::OP_AND_FILE, 1'b0, 3'h0, 7'd127, 8'h0, 1'b0);
        c(a_acc, 32'h34);
        c(fa(127), 32'h3c);
        c(a_st, 32'h3);
        wr(fa(0), 32'h0f);
        wr(a_acc, 32'hf0);
        ex(byte_alu_pkg::OP_AND_FILE, 1'b1, 3'h0, 7'd0, 8'h0, 1'b0);
        c(fa(0), 32'h0);
        c(a_acc, 32'hf0);
        c(a_st, 32'h7);
        wr(a_st, 32'h1);
        wr(a_acc, 32'h08);
        wr(fa(5), 32'h08);
        ex(byte_alu_pkg::OP_ADD_FILE, 1'b1, 3'h0, 7'd5, 8'h0, 1'b0);
        c(fa(5), 32'h10);
        c(a_st, 32'h2);
        wr(a_acc, 32'hf0);
        ex(byte_alu_pkg::OP_ADD_FILE, 1'b0, 3'h0, 7'd5, 8'h0, 1'b0);
        c(a_acc, 32'h0);
        c(a_st, 32'h5);
    endtask

    task automatic t_asr;
        wr(a_st, 32'h2);
        wr(fa(3), 32'h81);
        ex(byte_alu_pkg::OP_ASR_FILE, 1'b0, 3'h0, 7'd3, 8'h0, 1'b0);
        c(a_acc, 32'hc0);
        c(fa(3), 32'h81);
        c(a_st, 32'h3);
        wr(fa(3), 32'h40);
        ex(byte_alu_pkg::OP_ASR_FILE, 1'b1, 3'h0, 7'd3, 8'h0, 1'b0);
        c(fa(3), 32'h20);
        c(a_st, 32'h2);
        wr(fa(3), 32'h01);
        ex(byte_alu_pkg::OP_ASR_FILE, 1'b1, 3'h0, 7'd3, 8'h0, 1'b0);
        c(a_st, 32'h7);
    endtask

    task automatic t_addc;
        wr(a_st, 32'h1);
        wr(a_acc, 32'hff);
        wr(fa(9), 32'h0);
        ex(byte_alu_pkg::OP_ADDC_FILE, 1'b0, 3'h0, 7'd9, 8'h0, 1'b0);
        c(a_acc, 32'h0);
        c(a_st, 32'h7);
        wr(a_st, 32'h0);
        wr(a_acc, 32'h01);
        wr(fa(9), 32'h02);
        ex(byte_alu_pkg::OP_ADDC_FILE, 1'b1, 3'h0, 7'd9, 8'h0, 1'b0);
        c(fa(9), 32'h03);
        c(a_st, 32'h0);
    endtask

    // Clear every bit position in turn, flags untouched
    task automatic t_bclr;
        wr(a_st, 32'h7);
        wr(fa(10), 32'hff);
        for (int b = 0; b < 8; b++) begin
            ex(byte_alu_pkg::OP_BIT_CLEAR, b[0], 3'(b), 7'd10, 8'h0, 1'b0);
            c(fa(10), (32'hff << (b + 1)) & 32'hff);
        end
        c(a_st, 32'h7);
    endtask

    task automatic t_bad;
        wr(a_st, 32'h0);
        ex(byte_alu_pkg::op_t'(4'h9), 1'b0, 3'h0, 7'h0, 8'h0, 1'b0);
        c(a_st, 32'h8);
        ex(byte_alu_pkg::OP_NOP, 1'b0, 3'h0, 7'h0, 8'h0, 1'b0);
        c(a_st, 32'h0);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        RST = 1'b1;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        BREADY = 1'b0;
        ARVALID = 1'b0;
        RREADY = 1'b0;
        AWADDR = 12'h0;
        ARADDR = 12'h0;
        WDATA = 32'h0;
        WSTRB = 4'hf;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        t_reset;
        t_ptr;
        t_imm;
        t_file;
        t_asr;
        t_addc;
        t_bclr;
        t_bad;
        give_verdict;
    end

    // Watchdog
    initial begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule
